/* ocs_clock_switch.sv */
// The implementer's own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module ocs_clock_switch
(
    input  wire logic        pclk,                // 100 MHz clock.
    input  wire logic        presetn,             // Async reset, low.
    input  wire logic        psel,                // APB select.
    input  wire logic        penable,             // APB enable.
    input  wire logic        pwrite,              // APB direction.
    input  wire logic [7:0]  paddr,               // APB byte address.
    input  wire logic [31:0] pwdata,              // APB write data.
    output logic      [31:0] prdata,              // APB read data.
    output logic             pready,              // APB ready.
    output logic             pslverr,             // Unmapped access.
    input  wire logic        osc_in_pin,          // External clock.
    input  wire logic        sys_stop_osc_enable, // High outside stop.
    input  wire logic        run_in_stop_option,  // Keep osc in stop.
    output logic             source_rate_clock,   // Source tick.
    output logic             half_source_clock,   // Half-rate tick.
    output logic             bus_clock_en,        // Quarter-rate tick.
    output logic             osc_in_clock_mode,   // Input pin is clock.
    output logic             osc_out_pin,         // Output pin level.
    output logic             osc_out_pin_oe,      // Output pin drive.
    output logic      [1:0]  crystal_amp_range,   // Amplifier range.
    output logic             internal_osc_on      // Internal osc runs.
);
    import ocs_pkg::*;

    logic [1:0]        sel_r;
    logic [1:0]        range_r;
    logic [1:0]        freq_r;
    logic              req_r;
    logic              pinen_r;
    logic [7:0]        trim_r;
    logic              done_r;
    logic              int_run_r;
    logic              in_q_r;
    logic [1:0]        edge_cnt_r;
    logic [1:0]        div_cnt_r;
    ocs_state_e        state_r;
    ocs_state_e        state_nxt;
    logic [OCS_PW-1:0] base_period;
    logic [OCS_PW-1:0] int_period;
    logic              int_tick;

    // Bus decode; ready rises for the access cycle, no wait states.
    logic        acc_ok;
    logic        wr_en;
    logic        hit_ctrl;
    logic        hit_trim;
    logic        hit_stat;
    logic        mapped;
    logic [31:0] rd_data;
    assign acc_ok   = psel && penable && pready;
    assign wr_en    = acc_ok && pwrite && mapped;
    assign hit_ctrl = paddr == OCS_CTRL_OFS;
    assign hit_trim = paddr == OCS_TRIM_OFS;
    assign hit_stat = paddr == OCS_STAT_OFS;
    assign mapped   = hit_ctrl || hit_trim || hit_stat;

    // Read mux; reserved and unmapped bits read as zero.
    logic [31:0] ctrl_word;
    logic [31:0] stat_word;
    assign ctrl_word = {23'h0, done_r, pinen_r, req_r,
                        freq_r, range_r, sel_r};
    assign stat_word = {27'h0, state_r, int_run_r, done_r};
    assign rd_data   = hit_ctrl ? ctrl_word :
                       hit_trim ? {24'h0, trim_r} :
                       hit_stat ? stat_word : 32'h0;

    // Next control values from a write to the control word.
    logic       ctrl_wr;
    logic [1:0] sel_nxt;
    logic       pinen_nxt;
    assign ctrl_wr   = wr_en && hit_ctrl;
    assign sel_nxt   = ctrl_wr ? pwdata[OCS_SEL_LSB +: 2] : sel_r;
    assign pinen_nxt = (ctrl_wr ? pwdata[OCS_PINEN_BIT] : pinen_r)
                       && (sel_nxt != OCS_SRC_EXT);       // R18

    // Bus answer registers; read data is captured in the setup cycle.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end
        else
        begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata  <= (psel && !penable) ? rd_data : 32'h0;
        end
    end

    // Software-held control fields. The factory trim is never fetched
    // here; software must write it, so reset leaves the mid value.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sel_r   <= OCS_SRC_INT;
            range_r <= OCS_RANGE_RST;
            freq_r  <= OCS_FREQ_RST;                          // R2
            req_r   <= 1'b0;
            pinen_r <= 1'b0;
            trim_r  <= OCS_TRIM_RST;                          // R8
        end
        else
        begin
            pinen_r <= pinen_nxt;
            if (ctrl_wr)
            begin
                sel_r   <= sel_nxt;
                range_r <= pwdata[OCS_RANGE_LSB +: 2];
                freq_r  <= pwdata[OCS_FREQ_LSB +: 2];
                req_r   <= pwdata[OCS_REQ_BIT];                // R13
            end
            if (wr_en && hit_trim)
                trim_r <= pwdata[7:0];
        end
    end

    // Internal period: base rate from the select, then signed trim.
    // A bigger trim byte gives a longer period and a slower clock.
    assign base_period = (freq_r == OCS_FREQ_26M) ? OCS_PER_26M :
                         (freq_r == OCS_FREQ_13M) ? OCS_PER_13M :
                         (freq_r == OCS_FREQ_8M)  ? OCS_PER_8M  :
                                                    OCS_PER_4M;  // R2
    assign int_period  = base_period + {6'h0, trim_r}
                         - OCS_TRIM_MID;                       // R7

    ocs_int_osc
    #(
        .PW      (OCS_PW)
    )
    u_int_osc
    (
        .pclk    (pclk),
        .presetn (presetn),
        .run     (int_run_r),
        .period  (int_period),
        .step    (OCS_STEP),
        .tick    (int_tick)
    );

    // Stop gating: the system enable shuts oscillators down in stop
    // unless the run-in-stop option holds them on. A plain external
    // clock is not an oscillator of ours and is never gated.
    logic osc_run;
    logic is_int;
    logic is_ext;
    logic is_xtal;
    logic ext_rise;
    logic ext_ok;
    assign osc_run  = sys_stop_osc_enable || run_in_stop_option; // R4
    assign is_int   = sel_r == OCS_SRC_INT;                      // R16
    assign is_ext   = sel_r == OCS_SRC_EXT;                      // R16
    assign is_xtal  = sel_r == OCS_SRC_XTAL;                     // R16
    assign ext_rise = osc_in_pin && !in_q_r;
    assign ext_ok   = ext_rise && !is_int
                      && (is_ext || osc_run);                    // R4

    // Changeover sequence: wait for two live edges, then hand over.
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            OCS_ST_INT:
                if (req_r && !is_int)
                    state_nxt = OCS_ST_WAIT;
            OCS_ST_WAIT:
                if (!req_r || is_int)
                    state_nxt = OCS_ST_INT;
                else if (ext_ok
                         && edge_cnt_r == OCS_EDGE_NEED - 2'h1)
                    state_nxt = OCS_ST_EXT;                      // R14
            OCS_ST_EXT:
                if (!req_r && is_int)
                    state_nxt = OCS_ST_INT;                      // R17
            default:
                state_nxt = OCS_ST_INT;
        endcase
    end

    // Done is raised at the handover edge; the internal oscillator is
    // stopped one edge later, so no source gap or runt tick appears.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_r    <= OCS_ST_INT;
            done_r     <= 1'b0;
            int_run_r  <= 1'b1;
            in_q_r     <= 1'b0;
            edge_cnt_r <= 2'h0;
        end
        else
        begin
            state_r    <= state_nxt;
            done_r     <= state_nxt == OCS_ST_EXT;               // R15
            int_run_r  <= osc_run && !done_r;                    // R15
            in_q_r     <= osc_in_pin;
            edge_cnt_r <= (state_r != OCS_ST_WAIT) ? 2'h0 :
                          ext_ok ? edge_cnt_r + 2'h1 : edge_cnt_r;
        end
    end

    // Source tick: internal until done; the internal ticks keep
    // flowing through the whole confirmation wait.
    logic st_ext;
    logic src_tick;
    assign st_ext   = state_r == OCS_ST_EXT;
    assign src_tick = st_ext ? ext_ok : int_tick;                // R19

    // Pin control: the crystal owns the output pin as an amplifier;
    // internal or RC may put the source clock on it when enabled.
    logic pin_drive;
    assign pin_drive = pinen_r && (is_int || sel_r == OCS_SRC_RC)
                       && !st_ext;                               // R9

    // Dividers and pin outputs, all registered.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_cnt_r         <= 2'h0;
            source_rate_clock <= 1'b0;
            half_source_clock <= 1'b0;
            bus_clock_en      <= 1'b0;
            osc_in_clock_mode <= 1'b0;
            osc_out_pin       <= 1'b0;
            osc_out_pin_oe    <= 1'b0;
            crystal_amp_range <= OCS_RANGE_RST;
            internal_osc_on   <= 1'b1;
        end
        else
        begin
            div_cnt_r         <= src_tick ? div_cnt_r + 2'h1 : div_cnt_r;
            source_rate_clock <= src_tick;                       // R5
            half_source_clock <= src_tick && div_cnt_r[0];       // R6
            bus_clock_en      <= src_tick
                                 && div_cnt_r == OCS_DIV_LAST;   // R1
            osc_in_clock_mode <= !is_int;                        // R11
            osc_out_pin_oe    <= is_xtal || pin_drive;           // R11
            osc_out_pin       <= is_xtal ? !osc_in_pin
                                 : pin_drive && src_tick;        // R9
            crystal_amp_range <= range_r;                        // R3
            internal_osc_on   <= int_run_r;
        end
    end

    // Checks on the design's own behaviour.
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_handover;
        $rose(done_r) ##1 !int_run_r;
    endsequence

    sequence s_confirm;
        state_r == OCS_ST_WAIT && ext_ok && edge_cnt_r == 2'h1
            && req_r && !is_int;
    endsequence

    bus_quarter_a: assert property ( // R1
        bus_clock_en |-> half_source_clock && source_rate_clock
            && $past(div_cnt_r) == OCS_DIV_LAST)
        else $error("bus tick not on fourth source tick");

    reset_rate_a: assert property ( // R2
        freq_r == OCS_FREQ_4M && trim_r == OCS_TRIM_RST
            |-> int_period == OCS_PER_4M)
        else $error("default internal period wrong");

    xtal_range_a: assert property ( // R3
        ##1 crystal_amp_range == $past(range_r))
        else $error("crystal range not forwarded");

    stop_gate_a: assert property ( // R4
        !sys_stop_osc_enable && !run_in_stop_option
            |=> !int_run_r ##1 !internal_osc_on)
        else $error("oscillator ran in stop");

    ext_rate_a: assert property ( // R5
        st_ext && ext_ok |=> source_rate_clock)
        else $error("external edge lost");

    half_rate_a: assert property ( // R6
        half_source_clock |-> source_rate_clock
            && $past(div_cnt_r[0]))
        else $error("half clock off rate");

    trim_dir_a: assert property ( // R7
        trim_r > OCS_TRIM_RST
            |-> int_period > base_period)
        else $error("trim direction wrong");

    pin_out_a: assert property ( // R9
        is_int && pinen_r && int_tick && !st_ext
            |=> osc_out_pin && osc_out_pin_oe)
        else $error("clock not on output pin");

    in_mode_a: assert property ( // R11
        is_xtal |=> osc_out_pin_oe && osc_in_clock_mode)
        else $error("crystal pins not set up");

    two_edge_a: assert property ( // R14
        s_confirm |=> st_ext && done_r)
        else $error("no switch after second edge");

    early_switch_a: assert property ( // R14
        state_r == OCS_ST_WAIT && edge_cnt_r == 2'h0 |=> !st_ext)
        else $error("switched before two edges");

    done_first_a: assert property ( // R15
        $rose(done_r) |-> s_handover)
        else $error("internal osc not stopped after done");

    return_int_a: assert property ( // R17
        st_ext && !req_r && is_int |=> state_r == OCS_ST_INT && !done_r)
        else $error("no return to internal source");

    pin_force_a: assert property ( // R18
        is_ext |-> !pinen_r)
        else $error("pin enable not forced clear");

    keep_int_a: assert property ( // R19
        state_r == OCS_ST_WAIT && $past(osc_run) |-> int_run_r)
        else $error("internal clock stopped while waiting");
endmodule
`default_nettype wire

/* ocs_ext_clk_model.sv */
`timescale 1ns/1ps
`default_nettype none
// External clock source beside the block. While stopped it stands still
// low, as a gated oscillator would, so no stray edge counts as activity.
module ocs_ext_clk_model
(
    input  wire logic       pclk,      // System clock.
    input  wire logic       run,       // Source enabled.
    input  wire logic [7:0] half,      // Half period in pclk cycles.
    output logic            osc_in_pin // Clock into the block.
);
    logic [7:0] cnt;

    // Toggle after each half period; a large half period makes it slow.
    always @(posedge pclk)
    begin
        if (!run)
        begin
            osc_in_pin <= 1'b0;
            cnt        <= 8'h00;
        end
        else if (cnt >= half - 8'h01)
        begin
            osc_in_pin <= ~osc_in_pin;
            cnt        <= 8'h00;
        end
        else
        begin
            cnt <= cnt + 8'h01;
        end
    end
endmodule
`default_nettype wire

/* ocs_int_osc.sv */
`timescale 1ns/1ps
`default_nettype none
// Internal oscillator model: a fractional accumulator that emits one
// tick per oscillator period, so odd rates fit a single fast clock.
module ocs_int_osc
#(
    parameter int PW = 14
)
(
    input  wire logic          pclk,    // System clock.
    input  wire logic          presetn, // Async reset, active low.
    input  wire logic          run,     // Oscillator enabled.
    input  wire logic [PW-1:0] period,  // Period, 1/256 cycles.
    input  wire logic [PW-1:0] step,    // One pclk in 1/256 units.
    output logic               tick     // One pulse per period.
);
    logic [PW-1:0] acc_r;
    logic [PW-1:0] acc_sum;
    logic          wrap;

    // Wrap when a whole period has been accumulated.
    assign acc_sum = acc_r + step;
    assign wrap    = acc_sum >= period;

    // Stopped oscillator restarts from phase zero.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            acc_r <= '0;
            tick  <= 1'b0;
        end
        else if (!run)
        begin
            acc_r <= '0;
            tick  <= 1'b0;
        end
        else
        begin
            acc_r <= wrap ? acc_sum - period : acc_sum;
            tick  <= wrap;
        end
    end
endmodule
`default_nettype wire

/* ocs_pkg.sv */
// Notes on behaviour
// R1: Bus runs at one quarter of source.
// R2: Four internal rates; 4 MHz after reset.
// R3: Crystal mode offers three frequency ranges.
// R4: Stop disables oscillators unless run-in-stop set.
// R5: Times-four clock equals selected source rate.
// R6: Times-two clock is half the times-four.
// R7: Signed trim; larger trim lengthens period.
// R8: Software copies factory trim into register.
// R9: Internal source plus pin enable drives clock.
// R10: Software selects crystal first, may precharge.
// R11: External option makes input pin clock input.
// R12: Software waits stabilization before requesting switch.
// R13: Request bit set only after that delay.
// R14: Two external rising edges confirm activity first.
// R15: Done flag set before internal oscillator stops.
// R16: Select codes: internal, clock, RC, crystal.
// R17: Clearing select and request returns to internal.
// R18: External clock mode forces pin enable clear.
// R19: Internal clock keeps running while confirming.
`default_nettype none
package ocs_pkg;
    // Register byte offsets on the APB.
    localparam logic [7:0] OCS_CTRL_OFS = 8'h00;
    localparam logic [7:0] OCS_TRIM_OFS = 8'h04;
    localparam logic [7:0] OCS_STAT_OFS = 8'h08;

    // Control register field positions.
    localparam int OCS_SEL_LSB   = 0;
    localparam int OCS_RANGE_LSB = 2;
    localparam int OCS_FREQ_LSB  = 4;
    localparam int OCS_REQ_BIT   = 6;
    localparam int OCS_PINEN_BIT = 7;
    localparam int OCS_DONE_BIT  = 8;

    // Source select codes.
    localparam logic [1:0] OCS_SRC_INT  = 2'h0;
    localparam logic [1:0] OCS_SRC_EXT  = 2'h1;
    localparam logic [1:0] OCS_SRC_RC   = 2'h2;
    localparam logic [1:0] OCS_SRC_XTAL = 2'h3;

    // Internal frequency select codes.
    localparam logic [1:0] OCS_FREQ_4M  = 2'h0;
    localparam logic [1:0] OCS_FREQ_8M  = 2'h1;
    localparam logic [1:0] OCS_FREQ_13M = 2'h2;
    localparam logic [1:0] OCS_FREQ_26M = 2'h3;

    // Crystal range codes; the fourth code is passed to the amplifier unchanged.
    localparam logic [1:0] OCS_XR_LOW  = 2'h0;
    localparam logic [1:0] OCS_XR_MID  = 2'h1;
    localparam logic [1:0] OCS_XR_HIGH = 2'h2;

    // Reset values.
    localparam logic [7:0] OCS_TRIM_RST  = 8'h80;
    localparam logic [1:0] OCS_FREQ_RST  = OCS_FREQ_4M;
    localparam logic [1:0] OCS_RANGE_RST = OCS_XR_MID;

    // Rates in kHz; periods are pclk cycles in 1/256 units.
    localparam int OCS_PCLK_KHZ = 100000;
    localparam int OCS_F4_KHZ   = 4000;
    localparam int OCS_F8_KHZ   = 8000;
    localparam int OCS_F13_KHZ  = 12800;
    localparam int OCS_F26_KHZ  = 25600;
    localparam int OCS_FRAC     = 256;
    localparam int OCS_PW       = 14;
    localparam logic [OCS_PW-1:0] OCS_STEP = OCS_PW'(OCS_FRAC);
    localparam logic [OCS_PW-1:0] OCS_PER_4M =
        OCS_PW'(OCS_FRAC * OCS_PCLK_KHZ / OCS_F4_KHZ);
    localparam logic [OCS_PW-1:0] OCS_PER_8M =
        OCS_PW'(OCS_FRAC * OCS_PCLK_KHZ / OCS_F8_KHZ);
    localparam logic [OCS_PW-1:0] OCS_PER_13M =
        OCS_PW'(OCS_FRAC * OCS_PCLK_KHZ / OCS_F13_KHZ);
    localparam logic [OCS_PW-1:0] OCS_PER_26M =
        OCS_PW'(OCS_FRAC * OCS_PCLK_KHZ / OCS_F26_KHZ);
    localparam logic [OCS_PW-1:0] OCS_TRIM_MID = 14'h0080;

    // External rising edges needed before changeover.
    localparam logic [1:0] OCS_EDGE_NEED = 2'h2;
    localparam logic [1:0] OCS_DIV_LAST  = 2'h3;

    typedef enum logic [2:0]
    {
        OCS_ST_INT  = 3'b001,
        OCS_ST_WAIT = 3'b010,
        OCS_ST_EXT  = 3'b100
    } ocs_state_e;
endpackage
`default_nettype wire

/* testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import ocs_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, osc_in_pin;
    logic [7:0]  paddr, ext_half;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, stop_en, opt, ext_run, er, pv;
    logic        src_clk, half_clk, bus_en, in_mode, out_pin, out_oe, osc_on;
    logic [1:0]  amp;
    int          failures, n_checks, s, h, b, p, e, n, rises, s1;

    ocs_clock_switch u_ocs_clock_switch (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .osc_in_pin(osc_in_pin),
        .sys_stop_osc_enable(stop_en), .run_in_stop_option(opt),
        .source_rate_clock(src_clk), .half_source_clock(half_clk),
        .bus_clock_en(bus_en), .osc_in_clock_mode(in_mode),
        .osc_out_pin(out_pin), .osc_out_pin_oe(out_oe),
        .crystal_amp_range(amp), .internal_osc_on(osc_on));
    ocs_ext_clk_model u_ocs_ext_clk_model (.pclk(pclk), .run(ext_run),
        .half(ext_half), .osc_in_pin(osc_in_pin));

    // Free-running 100 MHz clock.
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Pulse counts drift by one at window edges, so a band is accepted.
    task automatic chk_rng(input int got, input int lo, input int hi);
        n_checks++;
        if (got < lo || got > hi)
        begin
            failures++;
            $display("[ERR] %0t got %h exp %h..%h", $time, got, lo, hi);
        end
    endtask

    // One APB transfer; the request holds until pready is seen high.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 50);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (k >= 50)
            chk(32'h0, 32'h1);
        // One idle edge, so a following call never reassigns psel at once.
        @(posedge pclk);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] x,
                          input logic xe);
        apb(1'b0, a, 32'h0);
        chk(rd, x);
        chk({31'h0, er}, {31'h0, xe});
    endtask

    task automatic count(input int cyc);
        s = 0;
        h = 0;
        b = 0;
        p = 0;
        repeat (cyc)
        begin
            @(posedge pclk);
            s += (src_clk === 1'b1);
            h += (half_clk === 1'b1);
            b += (bus_en === 1'b1);
            p += (out_pin === 1'b1);
        end
    endtask

    function automatic logic [31:0] ctrl(input logic [1:0] sl, rg, fq,
                                         input logic rq, pe);
        ctrl = 32'h0;
        ctrl[OCS_SEL_LSB +: 2]   = sl;
        ctrl[OCS_RANGE_LSB +: 2] = rg;
        ctrl[OCS_FREQ_LSB +: 2]  = fq;
        ctrl[OCS_REQ_BIT]        = rq;
        ctrl[OCS_PINEN_BIT]      = pe;
    endfunction

    // Status word: state one-hot, internal running, switch done.
    function automatic logic [31:0] stat(input ocs_state_e st,
                                         input logic run, dn);
        stat = {27'h0, st, run, dn};
    endfunction

    // Source pulses expected in a 1000-cycle window.
    function automatic int exp_src(input logic [1:0] f);
        int k;
        case (f)
            OCS_FREQ_4M: k = OCS_F4_KHZ;
            OCS_FREQ_8M: k = OCS_F8_KHZ;
            OCS_FREQ_13M: k = OCS_F13_KHZ;
            default: k = OCS_F26_KHZ;
        endcase
        return k * 1000 / OCS_PCLK_KHZ;
    endfunction

    // Watchdog: the whole sequence needs well under 20000 cycles.
    initial
    begin
        #200000;
        failures++;
        test_done();
    end

    initial
    begin
        {psel, penable, pwrite, ext_run, opt} = 5'h00;
        {paddr, pwdata, ext_half, failures, n_checks} = '0;
        stop_en = 1'b1;
        presetn = 1'b0;
        void'($urandom(6525));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk({31'h0, osc_on}, 32'h1);
        chk({30'h0, amp}, {30'h0, OCS_RANGE_RST});
        rd_chk(OCS_CTRL_OFS, ctrl(2'h0, 2'h1, 2'h0, 1'b0, 1'b0), 1'b0);
        rd_chk(OCS_TRIM_OFS, {24'h0, OCS_TRIM_RST}, 1'b0);
        rd_chk(OCS_STAT_OFS, stat(OCS_ST_INT, 1'b1, 1'b0), 1'b0);
        rd_chk(8'h0C, 32'h0, 1'b1);
        // Every internal rate, with the derived clocks beside it.
        for (int f = 0; f < 4; f++)
        begin
            apb(1'b1, OCS_CTRL_OFS, ctrl(2'h0, 2'h1, f[1:0], 1'b0, 1'b0));
            repeat (50) @(posedge pclk);
            count(1000);
            e = exp_src(f[1:0]);
            chk_rng(s, e - 1, e + 1);
            chk_rng(h, e / 2 - 1, e / 2 + 1);
            chk_rng(b, e / 4 - 1, e / 4 + 1);
        end
        // Trim at the low corner, then a random high value.
        apb(1'b1, OCS_TRIM_OFS, 32'h00);
        repeat (50) @(posedge pclk);
        count(1000);
        s1 = s;
        apb(1'b1, OCS_TRIM_OFS, {24'h0, 8'($urandom_range(192, 255))});
        repeat (50) @(posedge pclk);
        count(1000);
        chk_rng(s, 1, s1 - 10);
        apb(1'b1, OCS_TRIM_OFS, 32'h80);
        // Internal source with the pin enabled copies the source clock.
        apb(1'b1, OCS_CTRL_OFS, ctrl(2'h0, 2'h1, 2'h1, 1'b0, 1'b1));
        repeat (50) @(posedge pclk);
        count(500);
        chk_rng(p, s - 1, s + 1);
        chk({31'h0, out_oe}, 32'h1);
        // Crystal ranges; the output pin inverts the input pin.
        ext_half <= 8'h03;
        ext_run  <= 1'b1;
        for (int r = 0; r < 3; r++)
        begin
            apb(1'b1, OCS_CTRL_OFS, ctrl(2'h3, r[1:0], 2'h0, 1'b0, 1'b0));
            repeat (3) @(posedge pclk);
            chk({30'h0, amp}, 32'(r));
            chk({30'h0, in_mode, out_oe}, 32'h3);
            pv = osc_in_pin;
            repeat (20)
            begin
                @(posedge pclk);
                chk({31'h0, out_pin}, {31'h0, ~pv});
                pv = osc_in_pin;
            end
        end
        // RC option: input pin is a clock, output pin copies the source.
        apb(1'b1, OCS_CTRL_OFS, ctrl(2'h2, 2'h1, 2'h0, 1'b0, 1'b1));
        count(200);
        chk_rng(p, s - 1, s + 1);
        chk({30'h0, in_mode, out_oe}, 32'h3);
        // External clock mode refuses the pin enable.
        apb(1'b1, OCS_CTRL_OFS, ctrl(2'h1, 2'h1, 2'h0, 1'b0, 1'b1));
        repeat (3) @(posedge pclk);
        rd_chk(OCS_CTRL_OFS, ctrl(2'h1, 2'h1, 2'h0, 1'b0, 1'b0), 1'b0);
        chk({31'h0, out_oe}, 32'h0);
        // Switch request with the source silent: stays on internal clock.
        ext_run <= 1'b0;
        repeat (100) @(posedge pclk);
        apb(1'b1, OCS_CTRL_OFS, ctrl(2'h1, 2'h1, 2'h0, 1'b1, 1'b0));
        repeat (30) @(posedge pclk);
        rd_chk(OCS_STAT_OFS, stat(OCS_ST_WAIT, 1'b1, 1'b0), 1'b0);
        count(200);
        chk_rng(s, 7, 9);
        ext_half <= 8'h05;
        ext_run  <= 1'b1;
        rises = 0;
        n = 0;
        pv = 1'b0;
        do
        begin
            @(posedge pclk);
            if (osc_in_pin === 1'b1 && !pv)
                rises++;
            pv = osc_in_pin;
            n++;
        end
        while (osc_on === 1'b1 && n < 300);
        chk_rng(rises, 2, 2);
        rd_chk(OCS_STAT_OFS, stat(OCS_ST_EXT, 1'b0, 1'b1), 1'b0);
        rd_chk(OCS_CTRL_OFS, ctrl(2'h1, 2'h1, 2'h0, 1'b1, 1'b0) | 32'h100,
               1'b0);
        count(200);
        chk_rng(s, 19, 21);
        chk_rng(b, 4, 6);
        // Back to the internal source at the 8 MHz setting.
        apb(1'b1, OCS_CTRL_OFS, ctrl(2'h0, 2'h1, 2'h1, 1'b0, 1'b0));
        ext_run <= 1'b0;
        repeat (50) @(posedge pclk);
        rd_chk(OCS_STAT_OFS, stat(OCS_ST_INT, 1'b1, 1'b0), 1'b0);
        count(1000);
        chk_rng(s, 79, 81);
        // Stop mode gates the oscillator unless run-in-stop is set.
        stop_en <= 1'b0;
        repeat (10) @(posedge pclk);
        count(500);
        chk_rng(s, 0, 0);
        opt <= 1'b1;
        repeat (50) @(posedge pclk);
        count(500);
        chk_rng(s, 39, 41);
        test_done();
    end
endmodule
`default_nettype wire
